// *** hdl/sdl_pkg.sv ***
/*
 package for the serial converter input loader: widths, reset values and the
 packed carrier for words handed from the loader to the converter side.
 assumes a single core clock domain; serial pins sampled on that clock.
*/
package sdl_pkg;
   localparam int unsigned WORD_W = 12;
   localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
   localparam logic [WORD_W-1:0] WORD_ONE = 12'h001;
   localparam logic [3:0] CNT_MAX = 4'hc;
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [1:0] FILL_EMPTY = 2'h0;
   localparam logic [1:0] FILL_FULL = 2'h2;

   // word leaving the converter register, with a flag for a full 12-bit fill
   typedef struct packed {
      logic full;
      logic [WORD_W-1:0] data;
   } sdl_word_type;

   // loader condition as seen by the control process
   typedef enum logic [1:0] {
      SDL_IDLE,
      SDL_SHIFT,
      SDL_LOAD
   } sdl_state_type;
endpackage : sdl_pkg

// *** hdl/sdl_skid_buf.sv ***
/*
 two-entry buffer with valid/ready on both sides.
 assumes the consumer may hold ready low for any number of cycles.
*/
`timescale 1ns/100ps
module sdl_skid_buf (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // fill side
   input wire logic in_valid_i,
   input sdl_pkg::sdl_word_type in_word_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output sdl_pkg::sdl_word_type out_word_o,
   input wire logic out_ready_i
);
   sdl_pkg::sdl_word_type mem_ff [2];
   logic wr_ptr_ff;
   logic rd_ptr_ff;
   logic [1:0] fill_ff;
   logic do_wr;
   logic do_rd;

   // honest flags straight from the fill count
   assign in_ready_o = (fill_ff != sdl_pkg::FILL_FULL);
   assign out_valid_o = (fill_ff != sdl_pkg::FILL_EMPTY);
   assign out_word_o = mem_ff[rd_ptr_ff];
   assign do_wr = in_valid_i && in_ready_o;
   assign do_rd = out_valid_o && out_ready_i;

   // storage written only on an accepted word
   always_ff @(posedge core_clk_i) begin
      if (do_wr) begin
         mem_ff[wr_ptr_ff] <= in_word_i;
      end
   end

   // pointers and count
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         fill_ff <= sdl_pkg::FILL_EMPTY;
      end else begin
         if (do_wr) begin
            wr_ptr_ff <= ~wr_ptr_ff;
         end
         if (do_rd) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         fill_ff <= 2'(fill_ff + {1'b0, do_wr} - {1'b0, do_rd});
      end
   end

   a_buf_no_overflow: assert property (@(posedge core_clk_i) disable iff (srst_i)
      fill_ff <= sdl_pkg::FILL_FULL) else $error("buffer count beyond two");
endmodule // sdl_skid_buf

// *** hdl/sdl_loader.sv ***
/*
 serial input loader of a 12-bit multiplying converter: serial shift register,
 level-sensitive active-low load into the converter register.
 assumes serial clock, data and strobe are synchronous to core_clk_i; the
 serial clock is sampled and its rising edge detected on the core clock.
*/
`timescale 1ns/100ps
module sdl_loader (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // serial pins from the host
   input wire logic serial_clk_i,
   input wire logic serial_data_in_i,
   input wire logic load_strobe_n_i,
   // converter register towards the ladder, and the shift register behind it
   output logic [sdl_pkg::WORD_W-1:0] conv_word_o,
   output logic [sdl_pkg::WORD_W-1:0] shift_word_o,
   // loaded-word stream
   output logic load_valid_o,
   output sdl_pkg::sdl_word_type load_word_o,
   input wire logic load_ready_i,
   // status
   output logic word_full_o
);
   logic [sdl_pkg::WORD_W-1:0] shift_ff;
   logic [sdl_pkg::WORD_W-1:0] conv_ff;
   logic [3:0] cnt_ff;
   logic sclk_d_ff;
   logic strobe_d_ff;
   logic sclk_rise;
   logic strobe_rise;
   logic in_ready;
   sdl_pkg::sdl_state_type state;
   sdl_pkg::sdl_word_type push_word;

   // timing in core clock cycles: a serial clock rise seen at edge n shifts at edge n,
   // so shift_word_o shows the new bit from then on; a strobe-low edge copies the shift
   // register into the converter word at that edge; the rise that ends the pulse
   // pushes the held word, and the stream shows it from that edge on. pins are sampled
   // as they stand, so the host must hold each level for at least one cycle.

   // shift by one, new bit entering at the bottom so the first bit climbs to the top
   function automatic logic [sdl_pkg::WORD_W-1:0] shift_in(
      input logic [sdl_pkg::WORD_W-1:0] cur,
      input logic bit_in);
      shift_in = {cur[sdl_pkg::WORD_W-2:0], bit_in};
   endfunction

   // edge history of the two host pins; reset values match the idle pin levels so
   // that leaving reset never shows a false serial clock or strobe edge
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         sclk_d_ff <= 1'b0;
         strobe_d_ff <= 1'b1;
      end else begin
         sclk_d_ff <= serial_clk_i;
         strobe_d_ff <= load_strobe_n_i;
      end
   end

   assign sclk_rise = serial_clk_i && !sclk_d_ff;
   assign strobe_rise = load_strobe_n_i && !strobe_d_ff;

   // decode of the present operation, strobe low wins over shifting;
   // a serial clock rise under a low strobe is dropped, not held for later
   always_comb begin
      if (!load_strobe_n_i) begin
         state = sdl_pkg::SDL_LOAD;
      end else if (sclk_rise) begin
         state = sdl_pkg::SDL_SHIFT;
      end else begin
         state = sdl_pkg::SDL_IDLE;
      end
   end

   // shift register; the top bit falls off, so excess leading bits vanish
   // and a host may clock in a longer word with its padding in front
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         shift_ff <= sdl_pkg::WORD_RST;
      end else begin
         case (state)
            sdl_pkg::SDL_SHIFT: shift_ff <= shift_in(shift_ff, serial_data_in_i);
            sdl_pkg::SDL_LOAD: shift_ff <= shift_ff;
            sdl_pkg::SDL_IDLE: shift_ff <= shift_ff;
            default: shift_ff <= shift_ff;
         endcase
      end
   end

   // count of bits since the last load, saturating at a full word; a bit shifted on the
   // very edge of a strobe rise already belongs to the next word, so it counts as one
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cnt_ff <= sdl_pkg::CNT_RST;
      end else if (strobe_rise && state == sdl_pkg::SDL_SHIFT) begin
         cnt_ff <= sdl_pkg::CNT_ONE;
      end else if (strobe_rise) begin
         cnt_ff <= sdl_pkg::CNT_RST;
      end else if (state == sdl_pkg::SDL_SHIFT && cnt_ff != sdl_pkg::CNT_MAX) begin
         cnt_ff <= cnt_ff + sdl_pkg::CNT_ONE;
      end
   end

   // converter register is transparent while the strobe is low, latched otherwise;
   // a flop re-copied on every low edge stands in for a real latch
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         conv_ff <= sdl_pkg::WORD_RST;
      end else if (state == sdl_pkg::SDL_LOAD) begin
         conv_ff <= shift_ff;
      end
   end

   // one word pushed per load pulse at its closing edge; a full buffer drops it
   // rather than stalling the pins, since the host gives no wait signal
   // one driver for the whole carrier; the full flag rides beside the held word
   assign push_word = {(cnt_ff == sdl_pkg::CNT_MAX), conv_ff};
   sdl_skid_buf u_buf (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .in_valid_i(strobe_rise),
      .in_word_i(push_word),
      .in_ready_o(in_ready),
      .out_valid_o(load_valid_o),
      .out_word_o(load_word_o),
      .out_ready_i(load_ready_i)
   );

   // register outputs straight from the flops; the full flag is decoded from the count
   assign conv_word_o = conv_ff;
   assign shift_word_o = shift_ff;
   assign word_full_o = (cnt_ff == sdl_pkg::CNT_MAX);

   a_shift_one_bit: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (load_strobe_n_i && sclk_rise) |=> (shift_ff[0] == $past(serial_data_in_i)
         && shift_ff[sdl_pkg::WORD_W-1:1] == $past(shift_ff[sdl_pkg::WORD_W-2:0])))
      else $error("shift did not advance one bit");
   a_conv_held_shift: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (load_strobe_n_i && strobe_d_ff) |=> $stable(conv_ff))
      else $error("converter word changed while strobe high");
   a_conv_follows_shift: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !load_strobe_n_i |=> (conv_ff == $past(shift_ff) && $stable(shift_ff)))
      else $error("converter word not following shift register");
   a_latch_on_rise: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (strobe_rise && !serial_clk_i) |=> ($stable(conv_ff) && $stable(shift_ff)))
      else $error("latch edge disturbed a register");
   a_count_full: assert property (@(posedge core_clk_i) disable iff (srst_i)
      cnt_ff <= sdl_pkg::CNT_MAX) else $error("bit count beyond a word");
   a_reset_clears: assert property (@(posedge core_clk_i)
      srst_i |=> (conv_ff == sdl_pkg::WORD_RST && shift_ff == sdl_pkg::WORD_RST))
      else $error("reset left a register nonzero");

   // register, counter and stream-side checks; the buffer's own flags are read here only
   // no serial clock rise with the strobe high leaves the shift register alone
   a_shift_rests: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (load_strobe_n_i && !sclk_rise) |=> $stable(shift_ff))
      else $error("shift register moved without a serial clock rise");

   // serial clock rises under a low strobe are neither applied nor remembered
   a_low_ignores_clk: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!load_strobe_n_i && sclk_rise) |=> $stable(shift_ff))
      else $error("serial clock acted while the strobe was low");

   // the converter word only moves after an edge that saw the strobe low
   a_conv_moves_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !$stable(conv_ff) |-> $past(!load_strobe_n_i))
      else $error("converter word moved with the strobe high");

   // the bit count steps by one for every shift below a full word that is not on a strobe rise
   a_count_step: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (load_strobe_n_i && sclk_rise && !strobe_rise && cnt_ff != sdl_pkg::CNT_MAX)
         |=> (cnt_ff == $past(cnt_ff) + sdl_pkg::CNT_ONE))
      else $error("bit count did not step with a shift");

   // a strobe rise with no shift on the same edge starts the next word from empty
   a_full_clears: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (strobe_rise && !sclk_rise) |=> !word_full_o)
      else $error("full flag survived a load");

   // every accepted rise shows up as a buffered word on the next cycle
   a_push_valid: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (strobe_rise && in_ready) |=> load_valid_o)
      else $error("accepted load left the stream empty");

   // into an empty buffer the latched converter word appears at the head
   a_push_data: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (strobe_rise && !load_valid_o)
         |=> (load_word_o.data == $past(conv_ff)))
      else $error("pushed word differs from the converter word");

   // the full flag of that word reflects the count before the rise cleared it
   a_push_full: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (strobe_rise && !load_valid_o)
         |=> (load_word_o.full == $past(cnt_ff == sdl_pkg::CNT_MAX)))
      else $error("pushed word carries a wrong full flag");

   // a rise against a full, stalled buffer is dropped and the head stays put
   a_drop_full: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (strobe_rise && !in_ready && !load_ready_i)
         |=> (load_valid_o && $stable(load_word_o)))
      else $error("dropped load disturbed the buffered words");

   // an offered word stands unchanged until the consumer takes it
   a_word_stands: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (load_valid_o && !load_ready_i) |=> (load_valid_o && $stable(load_word_o)))
      else $error("offered word withdrawn before it was taken");

   // the stream only fills from a strobe rise, never on its own
   a_fill_from_rise: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $rose(load_valid_o) |-> $past(strobe_rise))
      else $error("stream word appeared without a load");

   // reset also empties the stream and the bit count
   a_reset_flags: assert property (@(posedge core_clk_i)
      srst_i |=> (!load_valid_o && !word_full_o))
      else $error("reset left the stream or count set");
endmodule // sdl_loader

// *** sim/sdl_host_model.sv ***
/*
 host model for the loader: drives serial clock, data and load strobe.
 assumes its tasks are called from the bench on the core clock.
*/
`timescale 1ns/100ps
module sdl_host_model (
   // clock
   input wire logic core_clk_i,
   // serial pins towards the loader
   output logic serial_clk_o,
   output logic serial_data_o,
   output logic load_strobe_n_o
);
   // idle: clock low, strobe high
   initial begin
      serial_clk_o = 1'b0;
      serial_data_o = 1'b0;
      load_strobe_n_o = 1'b1;
   end
   // data and clock rise together; data inverts after, so no stale bit is left
   task automatic put_bit(input logic b);
      @(posedge core_clk_i);
      serial_data_o <= b;
      serial_clk_o <= 1'b1;
      @(posedge core_clk_i);
      serial_clk_o <= 1'b0;
      serial_data_o <= ~b;
   endtask
   // strobe level, kept high by callers while shifting except in t_low
   task automatic set_load(input logic lvl);
      @(posedge core_clk_i);
      load_strobe_n_o <= lvl;
   endtask
endmodule // sdl_host_model

// *** sim/tb_top.sv ***
/*
 self-checking bench for the serial loader and its output buffer.
 assumes sdl_pkg and the host model are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic load_ready_i = 1'b0;
   logic sclk;
   logic sdata;
   logic sld_n;
   logic [11:0] conv_w;
   logic [11:0] shift_w;
   logic load_valid;
   logic full;
   sdl_pkg::sdl_word_type load_word;
   int failures = 0;
   int checks = 0;
   // 50 MHz core clock
   always #10 core_clk_i = ~core_clk_i;
   sdl_host_model host (.core_clk_i(core_clk_i), .serial_clk_o(sclk),
      .serial_data_o(sdata), .load_strobe_n_o(sld_n));
   sdl_loader dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .serial_clk_i(sclk),
      .serial_data_in_i(sdata), .load_strobe_n_i(sld_n), .conv_word_o(conv_w),
      .shift_word_o(shift_w), .load_valid_o(load_valid), .load_word_o(load_word),
      .load_ready_i(load_ready_i), .word_full_o(full));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // twelve bits, top bit first, with slack for the register to settle
   task automatic send(input logic [11:0] w);
      for (int i = 11; i >= 0; i--) host.put_bit(w[i]);
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask
   task automatic load;
      host.set_load(1'b0);
      repeat (2) @(posedge core_clk_i);
      host.set_load(1'b1);
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask
   // wait bounded for a buffered word, check it, then accept it
   task automatic take(input logic [12:0] exp);
      for (int n = 0; n < 10 && load_valid !== 1'b1; n++) @(negedge core_clk_i);
      chk({15'h0000, load_valid}, 16'h0001);
      chk({3'h0, load_word}, {3'h0, exp});
      @(posedge core_clk_i) load_ready_i <= 1'b1;
      @(posedge core_clk_i) load_ready_i <= 1'b0;
      @(negedge core_clk_i);
   endtask
   task automatic t_reset;
      chk({conv_w, shift_w[11:8]}, 16'h0000);
      chk({4'h0, shift_w}, 16'h0000);
      chk({14'h0000, load_valid, full}, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_word;
      send(12'ha5c);
      chk({4'h0, shift_w}, 16'h0a5c);
      chk({4'h0, conv_w}, 16'h0000);
      chk({15'h0000, full}, 16'h0001);
      load;
      chk({4'h0, conv_w}, 16'h0a5c);
      chk({15'h0000, full}, 16'h0000);
      take({1'b1, 12'ha5c});
      chk({15'h0000, load_valid}, 16'h0000);
      $display("test word done");
   endtask
   task automatic t_extra;
      send(12'h0f1);
      send(12'h23c);
      chk({4'h0, shift_w}, 16'h023c);
      load;
      take({1'b1, 12'h23c});
      $display("test extra done");
   endtask
   // shift rises during a low strobe must be ignored
   task automatic t_low;
      send(12'h3c5);
      chk({4'h0, conv_w}, 16'h023c);
      host.set_load(1'b0);
      repeat (3) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk({4'h0, conv_w}, 16'h03c5);
      send(12'hfff);
      chk({4'h0, shift_w}, 16'h03c5);
      chk({4'h0, conv_w}, 16'h03c5);
      host.set_load(1'b1);
      take({1'b1, 12'h3c5});
      $display("test low done");
   endtask
   // consumer stalls across three loads; the third finds the buffer full
   task automatic t_buf;
      send(12'h111);
      load;
      send(12'h222);
      load;
      send(12'h333);
      load;
      take({1'b1, 12'h111});
      take({1'b1, 12'h222});
      chk({15'h0000, load_valid}, 16'h0000);
      $display("test buffer done");
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk_i);
      srst_i <= 1'b0;
      @(negedge core_clk_i);
      t_reset;
      t_word;
      t_extra;
      t_low;
      t_buf;
      wrap_up;
   end
   // watchdog, well past the few hundred cycles the tests need
   initial begin
      repeat (4000) @(posedge core_clk_i);
      failures++;
      wrap_up;
   end
endmodule // tb_top
